//--- fbc_calib_ctrl.sv
// serial register file and RC calibration control for the dual low-pass filter
`include "fbc_params.svh"

module fbc_calib_ctrl (
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // four-wire serial port
  input  wire logic                spi_sen_n_i,
  input  wire logic                spi_sck_i,
  input  wire logic                spi_sdi_i,
  output logic                     spi_sdo_o,
  output logic                     spi_sdo_oe_o,
  // calibration pins and analog handshake
  input  wire logic                calibration_reference_clock_pin_i,
  input  wire logic                rc_threshold_i,
  input  wire logic [7:0]          stored_codes_i,
  output logic                     rc_charge_o,
  output logic                     doubler_en_o,
  output logic [6:0]               ref_rate_o,
  // filter setting
  output fbc_pkg::fbc_filter_t     filter_o
);

  // ========================================================================
  // pin synchronisers
  logic [1:0] sen_s_q, sck_s_q, sdi_s_q, ref_s_q, thr_s_q;
  logic [7:0] st1_q, st2_q;
  logic       sen_d1_q, sck_d1_q, ref_d1_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sen_s_q  <= 2'h3;
      sck_s_q  <= 2'h0;
      sdi_s_q  <= 2'h0;
      ref_s_q  <= 2'h0;
      thr_s_q  <= 2'h0;
      st1_q    <= 8'h00;
      st2_q    <= 8'h00;
      sen_d1_q <= 1'b1;
      sck_d1_q <= 1'b0;
      ref_d1_q <= 1'b0;
    end else begin
      sen_s_q  <= {sen_s_q[0], spi_sen_n_i};
      sck_s_q  <= {sck_s_q[0], spi_sck_i};
      sdi_s_q  <= {sdi_s_q[0], spi_sdi_i};
      ref_s_q  <= {ref_s_q[0], calibration_reference_clock_pin_i};
      thr_s_q  <= {thr_s_q[0], rc_threshold_i};
      st1_q    <= stored_codes_i;
      st2_q    <= st1_q;
      sen_d1_q <= sen_s_q[1];
      sck_d1_q <= sck_s_q[1];
      ref_d1_q <= ref_s_q[1];
    end
  end

  wire sen_n    = sen_s_q[1];
  wire sen_fall = sen_d1_q & ~sen_n;
  wire sen_rise = ~sen_d1_q & sen_n;
  wire sck_rise = ~sck_d1_q & sck_s_q[1] & ~sen_n;
  wire ref_rise = ~ref_d1_q & ref_s_q[1];
  wire ref_any  = ref_d1_q ^ ref_s_q[1];

  // ========================================================================
  // serial shifter: 24 data, 5 address, 3 chip address bits, MSB first
  logic [31:0] rx_q;
  logic [31:0] tx_q;
  logic [5:0]  bit_cnt_q;
  logic        sdo_q;
  logic        sdo_oe_q;
  logic [23:0] rd_data;
  logic [4:0]  rd_addr_q;

  wire        frame_full = (bit_cnt_q == `FBC_FRAME_BITS);
  wire        frame_ok   = sen_rise & frame_full & (rx_q[2:0] == `FBC_CHIP_ADDR);
  wire [4:0]  wr_addr    = rx_q[7:3];
  wire [23:0] wr_data    = rx_q[31:8];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_q      <= 32'h0000_0000;
      tx_q      <= 32'h0000_0000;
      bit_cnt_q <= 6'h00;
      sdo_q     <= 1'b0;
    end else if (sen_fall) begin
      bit_cnt_q <= 6'h00;
      tx_q      <= {rd_data, rd_addr_q, `FBC_CHIP_ADDR};
    end else if (sck_rise) begin
      rx_q      <= {rx_q[30:0], sdi_s_q[1]};
      sdo_q     <= tx_q[31];
      tx_q      <= {tx_q[30:0], 1'b0};
      if (!frame_full) begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // pin stays released until a full frame carries this chip address
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sdo_oe_q <= 1'b0;
    end else if (sen_rise && frame_full) begin
      sdo_oe_q <= (rx_q[2:0] == `FBC_CHIP_ADDR);
    end
  end

  // ========================================================================
  // host registers
  fbc_pkg::fbc_ctrl_t ctrl_q;
  logic               gain_q;
  logic [3:0]         coarse_q;
  logic [3:0]         trim_q;
  logic [6:0]         rate_q;
  logic               ovr_q;

  wire wr_ctrl  = frame_ok & (wr_addr == `FBC_OFS_CTRL);
  wire wr_band  = frame_ok & (wr_addr == `FBC_OFS_GAIN_BAND);
  wire wr_trim  = frame_ok & (wr_addr == `FBC_OFS_TRIM);
  wire wr_start = frame_ok & (wr_addr == `FBC_OFS_CAL_START);
  wire wr_rate  = frame_ok & (wr_addr == `FBC_OFS_REF_RATE);
  wire wr_rdsel = frame_ok & (wr_addr == `FBC_OFS_READ_ADDR);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q    <= '0;
      gain_q    <= 1'b0;
      coarse_q  <= `FBC_CODE_RST;
      trim_q    <= `FBC_CODE_RST;
      rate_q    <= `FBC_REF_RATE_RST;
      rd_addr_q <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.cal_en   <= wr_data[`FBC_CTRL_CAL_EN];   // RULE_03
        ctrl_q.doubler  <= wr_data[`FBC_CTRL_DOUBLER];
        ctrl_q.use_host <= wr_data[`FBC_CTRL_USE_HOST]; // RULE_16
      end
      if (wr_band) begin
        gain_q   <= wr_data[`FBC_GAIN_BIT];                     // RULE_20
        coarse_q <= wr_data[`FBC_COARSE_HI:`FBC_COARSE_LO];     // RULE_14
      end
      if (wr_trim) begin
        trim_q <= wr_data[`FBC_TRIM_HI:`FBC_TRIM_LO];           // RULE_15
      end
      if (wr_rate) begin
        rate_q <= wr_data[6:0];                                 // RULE_01
      end
      if (wr_rdsel) begin
        rd_addr_q <= wr_data[4:0];
      end
    end
  end

  // ========================================================================
  // calibration: count reference edges while the RC node charges
  fbc_pkg::fbc_cal_state_t state_q;
  fbc_pkg::fbc_cal_state_t state_d;
  logic [23:0]             count_q;
  logic                    charge_q;

  // doubler counts both edges, giving twice the resolution of slow references
  wire ref_tick   = ctrl_q.doubler ? ref_any : ref_rise;
  wire start_ok   = wr_start & ctrl_q.cal_en;                     // RULE_03
  wire count_full = &count_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fbc_pkg::CAL_IDLE,
      fbc_pkg::CAL_DONE: begin
        if (start_ok) begin
          state_d = fbc_pkg::CAL_MEASURE;                         // RULE_04
        end
      end
      fbc_pkg::CAL_MEASURE: begin
        if (thr_s_q[1] || count_full || !ctrl_q.cal_en) begin
          state_d = fbc_pkg::CAL_DONE;
        end
      end
      default: begin
        state_d = fbc_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= fbc_pkg::CAL_IDLE;
      count_q  <= 24'h00_0000;
      charge_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      charge_q <= (state_d == fbc_pkg::CAL_MEASURE);
      if (state_q != fbc_pkg::CAL_MEASURE && start_ok) begin
        count_q <= 24'h00_0000;                                   // RULE_22
      end else if (state_q == fbc_pkg::CAL_MEASURE && ref_tick && !count_full) begin
        count_q <= count_q + 24'h00_0001;                         // RULE_05
      end
    end
  end

  // a host write to the trim register flags the calibrated result as overridden until the next start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovr_q <= 1'b0;
    end else if (start_ok) begin
      ovr_q <= 1'b0;
    end else if (wr_trim) begin
      ovr_q <= 1'b1;                                              // RULE_07
    end
  end

  // ========================================================================
  // read-back
  wire [23:0] result_word = {1'b0, ovr_q,
                             (state_q == fbc_pkg::CAL_MEASURE),
                             (state_q == fbc_pkg::CAL_DONE),
                             count_q[19:0]};                      // RULE_06
  wire [23:0] ctrl_word   = {19'h0_0000, ctrl_q.use_host, 2'h0,
                             ctrl_q.doubler, ctrl_q.cal_en};
  wire [23:0] band_word   = {14'h0000, coarse_q, 5'h00, gain_q};

  assign rd_data =
      (rd_addr_q == `FBC_OFS_CTRL)       ? ctrl_word :
      (rd_addr_q == `FBC_OFS_GAIN_BAND)  ? band_word :
      (rd_addr_q == `FBC_OFS_TRIM)       ? {20'h0_0000, trim_q} :
      (rd_addr_q == `FBC_OFS_REF_RATE)   ? {17'h0_0000, rate_q} :
      (rd_addr_q == `FBC_OFS_CAL_RESULT) ? result_word :
      (rd_addr_q == `FBC_OFS_CAL_COUNT)  ? count_q :              // RULE_08
      (rd_addr_q == `FBC_OFS_STORED)     ? {16'h0000, st2_q} :
                                           24'h00_0000;

  // ========================================================================
  // filter codes: host codes while selected, stored codes otherwise
  // codes beyond the top band or trim step are clamped to the last one
  wire [3:0] coarse_sel = ctrl_q.use_host ? coarse_q : st2_q[7:4]; // RULE_16
  wire [3:0] trim_sel   = ctrl_q.use_host ? trim_q   : st2_q[3:0];
  wire [3:0] coarse_lim = (coarse_sel > `FBC_COARSE_MAX) ? `FBC_COARSE_MAX : coarse_sel;
  wire [3:0] trim_lim   = (trim_sel > `FBC_TRIM_MAX) ? `FBC_TRIM_MAX : trim_sel;

  fbc_pkg::fbc_filter_t filter_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filter_q <= '0;
    end else begin
      filter_q.gain_10db <= gain_q;                               // RULE_20
      filter_q.coarse    <= coarse_lim;                           // RULE_19
      filter_q.trim      <= trim_lim;                             // RULE_19
    end
  end

  // ========================================================================
  // outputs
  assign spi_sdo_o    = sdo_q;
  assign spi_sdo_oe_o = sdo_oe_q;
  assign rc_charge_o  = charge_q;
  assign doubler_en_o = ctrl_q.doubler;
  assign ref_rate_o   = rate_q;                                   // RULE_01
  assign filter_o     = filter_q;

endmodule : fbc_calib_ctrl

//--- fbc_params.svh
// offsets, field positions, reset values and constants of the filter calibration block
// ==========================================================================
// Operation
// [RULE_01] host programs reference clock rate 20-100 MHz; device uses it when measuring; the code only drives it on ref_rate_o and counting ignores it.
// [RULE_02] host enables the clock doubler for reference clocks of 20-40 MHz.
// [RULE_03] calibration enable bit must be set before a cycle starts.
// [RULE_04] any write to the start register begins one calibration cycle; the code ignores it while cal_en is clear or a cycle is measuring.
// [RULE_05] device counts reference clock cycles across an on-chip RC time constant.
// [RULE_06] the calibration value is readable at 08h once complete.
// [RULE_07] host may override the calibration result by writing 03h; the code only sets the override flag, and the filter still needs bit 4 of 01h.
// [RULE_08] the count is also readable at 09h; both locations are kept.
// [RULE_09] host computes coarse tune factor as count divided by 10370000.
// [RULE_10] host normalises target as wanted bandwidth times coarse tune factor.
// [RULE_11] host picks coarse code 0000-1000 whose range holds the target.
// [RULE_12] host computes trim ratio as target over the band's typical centre.
// [RULE_13] host picks trim code 0000-1011 whose range holds the trim ratio.
// [RULE_14] coarse band code comes from bits 9:6 of 02h.
// [RULE_15] trim code comes from bits 3:0 of 03h.
// [RULE_16] host codes reach the filter only while bit 4 of 01h is set.
// [RULE_17] host may retune from the earlier tune factor without recalibrating.
// [RULE_18] host estimates unknown tune factor from current codes read at 0Ah.
// [RULE_19] coarse and trim codes together cover 3.5 MHz to 50 MHz.
// [RULE_20] input gain is selectable between 0 dB and 10 dB.
// [RULE_21] calibration needs serial access and a valid reference clock on its pin.
// [RULE_22] last count stays stable until a new calibration cycle is started.
// [RULE_23] host reads trim code 1000 lower bound as 1.048.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

// ==========================================================================
// register offsets
`define FBC_OFS_READ_ADDR   5'h00
`define FBC_OFS_CTRL        5'h01
`define FBC_OFS_GAIN_BAND   5'h02
`define FBC_OFS_TRIM        5'h03
`define FBC_OFS_CAL_START   5'h04
`define FBC_OFS_REF_RATE    5'h05
`define FBC_OFS_CAL_RESULT  5'h08
`define FBC_OFS_CAL_COUNT   5'h09
`define FBC_OFS_STORED      5'h0A

// ==========================================================================
// field positions
`define FBC_CTRL_CAL_EN     0
`define FBC_CTRL_DOUBLER    1
`define FBC_CTRL_USE_HOST   4
`define FBC_GAIN_BIT        0
`define FBC_COARSE_HI       9
`define FBC_COARSE_LO       6
`define FBC_TRIM_HI         3
`define FBC_TRIM_LO         0
`define FBC_RES_DONE        20
`define FBC_RES_BUSY        21
`define FBC_RES_OVR         22

// ==========================================================================
// serial frame, reset values and code limits
`define FBC_CHIP_ADDR       3'h5
`define FBC_FRAME_BITS      6'h20
`define FBC_REF_RATE_RST    7'h50
`define FBC_CODE_RST        4'h0
`define FBC_COARSE_MAX      4'h8
`define FBC_TRIM_MAX        4'hB

`endif

//--- fbc_pkg.sv
// types shared by the filter calibration block
package fbc_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_MEASURE,
    CAL_DONE
  } fbc_cal_state_t;

  typedef struct packed {
    logic       gain_10db;
    logic [3:0] coarse;
    logic [3:0] trim;
  } fbc_filter_t;

  typedef struct packed {
    logic       use_host;
    logic       doubler;
    logic       cal_en;
  } fbc_ctrl_t;

endpackage : fbc_pkg

//--- fbc_calib_chk.sv
// port-level assertions for the filter calibration control block
`include "fbc_params.svh"

module fbc_calib_chk (
  // watched ports
  input wire logic                 core_clk_i, reset_n_i,
  input wire logic                 spi_sen_n_i, spi_sck_i, spi_sdi_i,
  input wire logic                 spi_sdo_o, spi_sdo_oe_o,
  input wire logic                 calibration_reference_clock_pin_i,
  input wire logic                 rc_threshold_i, rc_charge_o, doubler_en_o,
  input wire logic [7:0]           stored_codes_i,
  input wire logic [6:0]           ref_rate_o,
  input wire fbc_pkg::fbc_filter_t filter_o
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_measuring;
    rc_charge_o && !rc_threshold_i;
  endsequence
  sequence s_threshold_hit;
    rc_charge_o && rc_threshold_i;
  endsequence

  a_threshold_ends_charge: assert property (s_threshold_hit |-> ##[1:6] !rc_charge_o)
    else $error("charge outlived threshold");
  a_charge_holds_frame: assert property (s_measuring ##0 !spi_sen_n_i |=> rc_charge_o)
    else $error("charge dropped mid frame");
  a_start_after_frame: assert property ($rose(rc_charge_o) |-> spi_sen_n_i && $past(spi_sen_n_i))
    else $error("charge rose inside a frame");
  a_rate_write_only: assert property ($changed(ref_rate_o) |-> spi_sen_n_i)
    else $error("rate moved inside a frame");
  a_doubler_write_only: assert property ($changed(doubler_en_o) |-> spi_sen_n_i)
    else $error("doubler moved inside a frame");
  a_codes_in_range: assert property (filter_o.coarse <= `FBC_COARSE_MAX && filter_o.trim <= `FBC_TRIM_MAX)
    else $error("filter code out of range");
  a_filter_write_only: assert property ($changed(filter_o) |-> spi_sen_n_i)
    else $error("filter moved inside a frame");
  a_sdo_in_frame: assert property ($changed(spi_sdo_o) |-> !spi_sen_n_i || !$past(spi_sen_n_i, 6))
    else $error("sdo moved outside a frame");
endmodule : fbc_calib_chk

bind fbc_calib_ctrl fbc_calib_chk i_fbc_calib_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .spi_sen_n_i(spi_sen_n_i),
  .spi_sck_i(spi_sck_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
  .calibration_reference_clock_pin_i(calibration_reference_clock_pin_i),
  .rc_threshold_i(rc_threshold_i), .rc_charge_o(rc_charge_o), .doubler_en_o(doubler_en_o),
  .stored_codes_i(stored_codes_i), .ref_rate_o(ref_rate_o), .filter_o(filter_o));

//--- fbc_host_model.sv
// serial host model driving the four-wire port
module fbc_host_model (
  // clock
  input  wire logic core_clk_i,
  // serial pins
  output logic      spi_sen_n_o,
  output logic      spi_sck_o,
  output logic      spi_sdi_o,
  input  wire logic spi_sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // frame engine
  initial begin
    spi_sen_n_o = 1'b1;
    spi_sck_o   = 1'b0;
    spi_sdi_o   = 1'b0;
  end
  // five core cycles per phase: the pins are sampled, not clocked
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge core_clk_i);
    spi_sen_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_sdi_o = tx[i];
      repeat (5) @(negedge core_clk_i);
      spi_sck_o = 1'b1;
      repeat (5) @(negedge core_clk_i);
      spi_sck_o = 1'b0;
      rx[i] = spi_sdo_i;
    end
    repeat (3) @(negedge core_clk_i);
    spi_sen_n_o = 1'b1;
    spi_sdi_o   = ~spi_sdi_o;
    // long gap also lets the write land before the caller looks
    repeat (8) @(negedge core_clk_i);
  endtask : xfer
endmodule : fbc_host_model

//--- tb.sv
// self-checking bench for the filter calibration control block
`include "fbc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk_i, reset_n_i, ref_clk, rc_thr, sen_n, sck, sdi, sdo, sdo_oe;
  logic                 charge, dbl;
  wire logic            sdo_line;
  logic [6:0]           rate;
  fbc_pkg::fbc_filter_t filt;
  logic [23:0]          d, cnt;
  int                   fail_count, checked;
  `define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: %s", $time, m); end end

  assign sdo_line = sdo_oe ? sdo : 1'bz;

  fbc_calib_ctrl i_fbc_calib_ctrl (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .spi_sen_n_i(sen_n), .spi_sck_i(sck), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
    .spi_sdo_oe_o(sdo_oe), .calibration_reference_clock_pin_i(ref_clk),
    .rc_threshold_i(rc_thr), .stored_codes_i(8'h3A), .rc_charge_o(charge),
    .doubler_en_o(dbl), .ref_rate_o(rate), .filter_o(filt));
  fbc_host_model i_fbc_host_model (.core_clk_i(core_clk_i), .spi_sen_n_o(sen_n),
    .spi_sck_o(sck), .spi_sdi_o(sdi), .spi_sdo_i(sdo_line));

  // ==========================================================================
  // clocks and tasks
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // 20 MHz reference, offset so it never meets a core edge
  initial begin
    ref_clk = 1'b0;
    #2;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic xf(input logic [4:0] a, input logic [23:0] wd, input logic [2:0] ca,
                    output logic [23:0] rd);
    logic [31:0] rx;
    i_fbc_host_model.xfer({wd, a, ca}, rx);
    rd = rx[31:8];
  endtask : xf

  task automatic wr(input logic [4:0] a, input logic [23:0] wd);
    logic [23:0] t;
    xf(a, wd, 3'h5, t);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [23:0] v);
    wr(`FBC_OFS_READ_ADDR, {19'h0, a});
    xf(`FBC_OFS_READ_ADDR, {19'h0, a}, 3'h5, v);
  endtask : rd

  task automatic wait_charge(input logic lvl);
    int n;
    n = 0;
    while (charge !== lvl && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    if (charge !== lvl) begin
      fail_count++;
      $display("unexpected at %0t: charge wait ran out", $time);
      test_done();
    end
  endtask : wait_charge

  // ==========================================================================
  // tests
  initial begin
    reset_n_i = 1'b0;
    rc_thr = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (10) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    `CHK(rate, 7'h50, "reset rate")
    `CHK({dbl, charge}, 2'b00, "reset control outputs")
    `CHK(filt[7:0], 8'h3A, "stored codes not applied")
    rd(`FBC_OFS_STORED, d);
    `CHK(d[7:0], 8'h3A, "stored codes readback")
    $display("test reset done");
    wr(`FBC_OFS_REF_RATE, 24'h14);
    `CHK(rate, 7'h14, "rate not taken")
    wr(`FBC_OFS_CTRL, 24'h3);
    `CHK(dbl, 1'b1, "doubler off")
    wr(`FBC_OFS_CAL_START, 24'h0);
    wait_charge(1'b1);
    repeat (200) @(negedge core_clk_i);
    rc_thr = 1'b1;
    wait_charge(1'b0);
    rc_thr = 1'b0;
    rd(`FBC_OFS_CAL_RESULT, d);
    `CHK(d[21:20], 2'b01, "not done or still busy")
    rd(`FBC_OFS_CAL_COUNT, cnt);
    `CHK(cnt[19:0], d[19:0], "count locations differ")
    `CHK(cnt >= 24'd76 && cnt <= 24'd92, 1'b1, "count off")
    $display("test calibration done");
    wr(`FBC_OFS_CTRL, 24'h2);
    wr(`FBC_OFS_CAL_START, 24'h0);
    `CHK(charge, 1'b0, "start taken while disabled")
    rd(`FBC_OFS_CAL_COUNT, d);
    `CHK(d, cnt, "count moved")
    $display("test refused start done");
    wr(`FBC_OFS_GAIN_BAND, 24'h1C1);
    wr(`FBC_OFS_TRIM, 24'h9);
    `CHK(filt[7:0], 8'h3A, "host codes used early")
    rd(`FBC_OFS_CAL_RESULT, d);
    `CHK(d[22], 1'b1, "override flag clear")
    wr(`FBC_OFS_CTRL, 24'h12);
    `CHK(filt.coarse, 4'h7, "coarse code")
    `CHK(filt.trim, 4'h9, "trim code")
    `CHK(filt.gain_10db, 1'b1, "gain select")
    // retune from the stored tune factor: band 5, trim at the 1.048 boundary, no new start
    wr(`FBC_OFS_GAIN_BAND, 24'h140);
    `CHK(filt.coarse, 4'h5, "retune coarse code")
    `CHK(filt.gain_10db, 1'b0, "retune gain")
    `CHK(charge, 1'b0, "retune started a cycle")
    wr(`FBC_OFS_TRIM, 24'h8);
    `CHK(filt.trim, 4'h8, "retune trim code")
    wr(`FBC_OFS_TRIM, 24'hF);
    `CHK(filt.trim, 4'hB, "trim not clamped")
    $display("test codes done");
    xf(`FBC_OFS_REF_RATE, 24'h40, 3'h2, d);
    `CHK(rate, 7'h14, "foreign write taken")
    `CHK(sdo_oe, 1'b0, "sdo still driven")
    rd(5'h1F, d);
    `CHK(d, 24'h0, "unmapped read")
    $display("test refusals done");
    test_done();
  end
endmodule : tb
